//--- design/isa_pkg.sv
// Constants shared by the slave addressing block
package isa_pkg;
  // Status codes reported to software
  localparam logic [7:0] CODE_ADDR_WRITE = 8'h44;
  localparam logic [7:0] CODE_DATA_NACK = 8'h48;
  localparam logic [7:0] CODE_GC_NACK = 8'h4A;
  localparam logic [7:0] CODE_DATA_ACK = 8'h4C;
  localparam logic [7:0] CODE_GC_ACK = 8'h4E;
  localparam logic [7:0] CODE_ADDR_READ = 8'h54;
  localparam logic [7:0] CODE_STOP = 8'h30;
  localparam logic [7:0] CODE_RESET = 8'h00;
  // Special address and data values
  localparam logic [7:0] GC_ADDR = 8'h00;
  localparam logic [7:0] GC_RESET_BYTE = 8'h06;
  localparam logic [4:0] WIDE_PREFIX = 5'h1E;
  // Field positions in the upper identifier
  localparam int UPPER_VALID_POS = 7;
  localparam int UPPER_ADDR_LSB = 0;
  // Bit counter landmarks within one byte frame
  localparam logic [3:0] CNT_LAST_DATA = 4'h7;
  localparam logic [3:0] CNT_ACK = 4'h8;
  localparam logic [3:0] CNT_DONE = 4'h9;
  // Transfer phases
  typedef enum logic [2:0] {
    PH_IDLE,
    PH_ADDR1,
    PH_ADDR2,
    PH_DATA,
    PH_SKIP
  } isa_phase_t;
endpackage

//--- design/isa_slave.sv
// Slave addressing and receive sequencer of the serial bus controller
`timescale 1ns/1ns
`default_nettype none

module isa_slave (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  // Serial bus pins, open drain
  input wire logic i_scl,
  output logic o_scl_out,
  output logic o_scl_oe,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe,
  // Configuration
  input wire logic i_slave_mode_enable,
  input wire logic i_broadcast_call_enable,
  input wire logic i_wide_address_enable,
  input wire logic [7:0] i_own_address_upper,
  input wire logic [7:0] i_own_address_lower,
  input wire logic [9:0] i_own_address_mask,
  // Software control
  input wire logic i_ack_reply_select,
  input wire logic i_event_clear,
  input wire logic i_start_request,
  // Status
  output logic [7:0] o_transfer_state_code,
  output logic o_transfer_event_flag,
  output logic [7:0] o_rx_data,
  output logic o_chip_reset,
  output logic o_master_request
);
  import isa_pkg::*;

  typedef struct packed {
    logic scl_s1;
    logic scl_s2;
    logic scl_d;
    logic sda_s1;
    logic sda_s2;
    logic sda_d;
    isa_phase_t phase;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic do_ack;
    logic sda_oe;
    logic scl_oe;
    logic gc;
    logic gc_first;
    logic wide_sel;
    logic selected;
    logic ack_sel;
    logic pend_evt;
    logic pend_rst;
    logic [7:0] pend_code;
    logic flag;
    logic [7:0] code;
    logic [7:0] rx_data;
    logic chip_rst;
    logic master_req;
  } isa_state_t;

  isa_state_t st;
  isa_state_t next_st;

  // Masked compare; a set mask bit forces that position to match
  function automatic logic addr_hit(input logic [9:0] rx, input logic [9:0] own,
                                    input logic [9:0] mask);
    addr_hit = &((rx ~^ own) | mask);
  endfunction

  // Bus conditions seen through the synchronisers, and decoded configuration
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic [7:0] byte_in;
  logic cmp_valid;
  logic wide_on;
  logic narrow_on;
  logic [1:0] own_upper;

  assign scl_rise = st.scl_s2 & ~st.scl_d;
  assign scl_fall = ~st.scl_s2 & st.scl_d;
  assign bus_start = st.scl_s2 & st.scl_d & st.sda_d & ~st.sda_s2;
  assign bus_stop = st.scl_s2 & st.scl_d & ~st.sda_d & st.sda_s2;
  assign byte_in = {st.shift[6:0], st.sda_s2};
  assign cmp_valid = i_own_address_upper[UPPER_VALID_POS];
  assign own_upper = i_own_address_upper[UPPER_ADDR_LSB +: 2];
  // Wide mode needs both enables and a live comparator
  assign wide_on = i_slave_mode_enable & i_wide_address_enable & cmp_valid;
  assign narrow_on = i_slave_mode_enable & ~i_wide_address_enable & cmp_valid;

  // Next state of the whole block
  always_comb begin
    next_st = st;
    next_st.chip_rst = 1'b0;
    next_st.scl_s1 = i_scl;
    next_st.scl_s2 = st.scl_s1;
    next_st.scl_d = st.scl_s2;
    next_st.sda_s1 = i_sda;
    next_st.sda_s2 = st.sda_s1;
    next_st.sda_d = st.sda_s2;

    // Mastership request drops as soon as software withdraws it
    if (!i_start_request) begin
      next_st.master_req = 1'b0;
    end

    // Software service: clearing releases the stalled step
    if (i_event_clear && st.flag) begin
      next_st.flag = 1'b0;
      next_st.scl_oe = 1'b0;
      next_st.ack_sel = i_ack_reply_select;
      if (st.code == CODE_STOP) begin
        next_st.master_req = i_start_request;
      end
    end

    // Bus events come after the clear so a new event is never lost
    if (bus_stop) begin
      if (st.selected) begin
        next_st.flag = 1'b1;
        next_st.code = CODE_STOP;
      end
      next_st.phase = PH_IDLE;
      next_st.selected = 1'b0;
      next_st.gc = 1'b0;
      next_st.wide_sel = 1'b0;
      next_st.sda_oe = 1'b0;
      next_st.scl_oe = 1'b0;
      next_st.do_ack = 1'b0;
      next_st.pend_evt = 1'b0;
      next_st.pend_rst = 1'b0;
    end else if (bus_start) begin
      // Wide selection survives a repeated start for the read turn
      next_st.phase = i_slave_mode_enable ? PH_ADDR1 : PH_IDLE;
      next_st.bit_cnt = 4'h0;
      next_st.sda_oe = 1'b0;
      next_st.do_ack = 1'b0;
      next_st.gc = 1'b0;
      next_st.selected = 1'b0;
      next_st.pend_evt = 1'b0;
      next_st.pend_rst = 1'b0;
    end else if (scl_rise && st.phase != PH_IDLE) begin
      if (st.bit_cnt <= CNT_LAST_DATA) begin
        next_st.shift = byte_in;
      end
      next_st.bit_cnt = st.bit_cnt + 4'h1;
      if (st.bit_cnt == CNT_LAST_DATA) begin
        // Whole byte in: decide reply and pending event
        unique case (st.phase)
          PH_ADDR1: begin
            if (byte_in == GC_ADDR && i_slave_mode_enable && i_broadcast_call_enable) begin
              next_st.do_ack = 1'b1;
              next_st.gc = 1'b1;
              next_st.gc_first = 1'b1;
              next_st.selected = 1'b1;
              next_st.ack_sel = 1'b1;
              next_st.phase = PH_DATA;
            end else if (wide_on && byte_in[7:3] == WIDE_PREFIX &&
                         addr_hit({byte_in[2:1], 8'h00}, {own_upper, 8'h00},
                                  i_own_address_mask)) begin
              if (!byte_in[0]) begin
                next_st.do_ack = 1'b1;
                next_st.wide_sel = 1'b0;
                next_st.phase = PH_ADDR2;
              end else if (st.wide_sel) begin
                // Same upper byte after repeated start: read turn
                next_st.do_ack = 1'b1;
                next_st.selected = 1'b1;
                next_st.pend_evt = 1'b1;
                next_st.pend_code = CODE_ADDR_READ;
                next_st.phase = PH_SKIP;
              end else begin
                next_st.phase = PH_SKIP;
              end
            end else if (narrow_on &&
                         addr_hit({3'h0, byte_in[7:1]}, {3'h0, i_own_address_lower[6:0]},
                                  {3'h0, i_own_address_mask[6:0]})) begin
              next_st.do_ack = 1'b1;
              next_st.selected = 1'b1;
              next_st.pend_evt = 1'b1;
              next_st.pend_code = byte_in[0] ? CODE_ADDR_READ : CODE_ADDR_WRITE;
              next_st.phase = byte_in[0] ? PH_SKIP : PH_DATA;
            end else begin
              // Not for us; a different upper byte also ends a wide session
              next_st.wide_sel = 1'b0;
              next_st.phase = PH_SKIP;
            end
          end
          PH_ADDR2: begin
            if (addr_hit({2'h0, byte_in}, {2'h0, i_own_address_lower},
                         {2'h0, i_own_address_mask[7:0]})) begin
              next_st.do_ack = 1'b1;
              next_st.selected = 1'b1;
              next_st.wide_sel = 1'b1;
              next_st.pend_evt = 1'b1;
              next_st.pend_code = CODE_ADDR_WRITE;
              next_st.phase = PH_DATA;
            end else begin
              next_st.phase = PH_SKIP;
            end
          end
          PH_DATA: begin
            next_st.rx_data = byte_in;
            next_st.do_ack = st.ack_sel;
            next_st.gc_first = 1'b0;
            if (st.gc) begin
              next_st.pend_code = st.ack_sel ? CODE_GC_ACK : CODE_GC_NACK;
            end else begin
              next_st.pend_code = st.ack_sel ? CODE_DATA_ACK : CODE_DATA_NACK;
            end
            // Reset byte after broadcast replaces the event entirely
            if (st.gc && st.gc_first && byte_in == GC_RESET_BYTE) begin
              next_st.pend_rst = 1'b1;
              next_st.pend_evt = 1'b0;
            end else begin
              next_st.pend_evt = 1'b1;
            end
            if (!st.ack_sel) begin
              next_st.phase = PH_SKIP;
            end
          end
          default: begin
            next_st.do_ack = 1'b0;
          end
        endcase
      end
    end else if (scl_fall && st.phase != PH_IDLE) begin
      // Acknowledge slot opens on the fall after the eighth bit
      if (st.bit_cnt == CNT_ACK && st.do_ack) begin
        next_st.sda_oe = 1'b1;
      end
      // Ack slot over: release data, post event, stall the clock
      if (st.bit_cnt == CNT_DONE) begin
        next_st.sda_oe = 1'b0;
        next_st.bit_cnt = 4'h0;
        next_st.do_ack = 1'b0;
        if (st.pend_evt) begin
          next_st.flag = 1'b1;
          next_st.code = st.pend_code;
          next_st.scl_oe = 1'b1;
        end
        if (st.pend_rst) begin
          next_st.chip_rst = 1'b1;
        end
        next_st.pend_evt = 1'b0;
        next_st.pend_rst = 1'b0;
      end
    end
  end

  // State register; the pins idle high so the synchronisers start released
  always_ff @(posedge i_ref_clk) begin
    if (!i_reset_n) begin
      st <= '0;
      st.scl_s1 <= 1'b1;
      st.scl_s2 <= 1'b1;
      st.scl_d <= 1'b1;
      st.sda_s1 <= 1'b1;
      st.sda_s2 <= 1'b1;
      st.sda_d <= 1'b1;
      st.phase <= PH_IDLE;
      st.code <= CODE_RESET;
    end else begin
      st <= next_st;
    end
  end

  // Outputs; the pins only ever pull low
  assign o_scl_out = 1'b0;
  assign o_sda_out = 1'b0;
  assign o_scl_oe = st.scl_oe;
  assign o_sda_oe = st.sda_oe;
  assign o_transfer_state_code = st.code;
  assign o_transfer_event_flag = st.flag;
  assign o_rx_data = st.rx_data;
  assign o_chip_reset = st.chip_rst;
  assign o_master_request = st.master_req;

  // Clock stretching only happens behind a pending event
  a_stretch_needs_flag: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    o_scl_oe |-> o_transfer_event_flag)
    else $error("clock held low without pending event");

  // Flag persists until software clears it
  a_flag_held: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (o_transfer_event_flag && !i_event_clear) |=> o_transfer_event_flag)
    else $error("event flag dropped without clear");

  // Stop of a selected transfer posts the stop code next cycle
  a_stop_reports: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    (bus_stop && st.selected) |=> (o_transfer_event_flag && o_transfer_state_code == CODE_STOP))
    else $error("stop not reported");

  // Chip reset only for the reset byte
  a_reset_byte: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    o_chip_reset |-> (o_rx_data == GC_RESET_BYTE && st.gc && !$rose(o_transfer_event_flag)))
    else $error("chip reset without reset byte");

  // Broadcast accepted only with both enables
  a_gc_enables: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    $rose(st.gc) |-> $past(i_slave_mode_enable && i_broadcast_call_enable))
    else $error("broadcast accepted while disabled");

  // Acked data byte reports the ack code
  a_ack_code: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    ($rose(o_transfer_event_flag) && o_transfer_state_code == CODE_DATA_ACK) |-> st.ack_sel)
    else $error("ack code with ack select low");

  // Refused data byte reports the refusal code
  a_nack_code: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    ($rose(o_transfer_event_flag) && o_transfer_state_code == CODE_DATA_NACK) |-> !st.ack_sel)
    else $error("refusal code with ack select high");

  // Broadcast data events carry only the broadcast codes
  a_gc_code: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    ($rose(o_transfer_event_flag) && st.gc) |->
      (o_transfer_state_code == CODE_GC_ACK || o_transfer_state_code == CODE_GC_NACK))
    else $error("broadcast event with wrong code");

  // Wide selection needs the comparator valid bit
  a_wide_valid: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    $rose(st.wide_sel) |-> $past(cmp_valid && i_wide_address_enable))
    else $error("wide selection with comparator off");

  // Own write address event leads into the data phase
  a_addr_write: assert property (@(posedge i_ref_clk) disable iff (!i_reset_n)
    ($rose(o_transfer_event_flag) && o_transfer_state_code == CODE_ADDR_WRITE) |->
      (st.phase == PH_DATA && st.selected))
    else $error("address event outside data phase");

endmodule

`default_nettype wire

//--- verification/isa_master.sv
// Behavioural serial bus master facing the slave addressing block
`timescale 1ns/1ns
`default_nettype none
module isa_master (
  // Pacing clock
  input wire logic i_clk,
  // Resolved bus levels
  input wire logic i_scl,
  input wire logic i_sda,
  // Open drain pulls and last ack seen
  output logic o_scl_low,
  output logic o_sda_low,
  output logic o_ack
);
  // Bus idle, both lines left to the pull-ups
  initial begin
    o_scl_low = 1'b0;
    o_sda_low = 1'b0;
    o_ack = 1'b0;
  end
  // Four block clocks make half of the 160 ns bus period
  task automatic pace(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  // Release clock; bounded wait while the slave stretches it
  task automatic rise();
    o_scl_low = 1'b0;
    for (int k = 0; k < 4000 && i_scl !== 1'b1; k++) begin
      @(negedge i_clk);
    end
    pace(4);
  endtask
  // Start, or repeated start when the clock is already held low
  task automatic start();
    if (o_scl_low) begin
      pace(1);
      o_sda_low = 1'b0;
      pace(3);
      rise();
    end
    o_sda_low = 1'b1;
    pace(4);
    o_scl_low = 1'b1;
  endtask
  // Byte MSB first, then a ninth clock with data released
  task automatic send(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      pace(1);
      o_sda_low = ~b[i];
      pace(3);
      rise();
      o_scl_low = 1'b1;
    end
    pace(1);
    o_sda_low = 1'b0;
    pace(3);
    rise();
    o_ack = (i_sda === 1'b0);
    o_scl_low = 1'b1;
  endtask
  // Stop: data rises while the clock is high
  task automatic stop();
    pace(1);
    o_sda_low = 1'b1;
    pace(3);
    rise();
    o_sda_low = 1'b0;
    pace(4);
  endtask
endmodule
`default_nettype wire

//--- verification/isa_slave_test.sv
// Self-checking bench for the slave addressing block
`timescale 1ns/1ns
`default_nettype none
module isa_slave_test;
  import isa_pkg::*;
  logic clk, rst_n, sme, bce, wae, ack_sel, clr, start_req;
  logic [7:0] upper, lower, code, rxd;
  logic [7:0] n_rst = 8'h00;
  logic scl_out, sda_out;
  logic [9:0] mask;
  logic scl_oe, sda_oe, evt, crst, mreq, m_scl, m_sda, m_ack;
  int n_mismatch = 0;
  int compares = 0;
  wire logic scl_bus;
  wire logic sda_bus;
  // Pull-ups: a line is low only while some party pulls it
  assign scl_bus = ~(m_scl | scl_oe);
  assign sda_bus = ~(m_sda | sda_oe);

  isa_slave uut (.i_ref_clk(clk), .i_reset_n(rst_n), .i_scl(scl_bus), .o_scl_out(scl_out),
    .o_scl_oe(scl_oe), .i_sda(sda_bus), .o_sda_out(sda_out), .o_sda_oe(sda_oe),
    .i_slave_mode_enable(sme), .i_broadcast_call_enable(bce), .i_wide_address_enable(wae),
    .i_own_address_upper(upper), .i_own_address_lower(lower), .i_own_address_mask(mask),
    .i_ack_reply_select(ack_sel), .i_event_clear(clr), .i_start_request(start_req),
    .o_transfer_state_code(code), .o_transfer_event_flag(evt), .o_rx_data(rxd),
    .o_chip_reset(crst), .o_master_request(mreq));
  isa_master m (.i_clk(clk), .i_scl(scl_bus), .i_sda(sda_bus), .o_scl_low(m_scl),
    .o_sda_low(m_sda), .o_ack(m_ack));

  // 50 MHz clock
  always #10 clk = ~clk;
  // Count chip reset pulses, one per clock they stand
  always @(posedge clk) begin
    if (crst === 1'b1) begin
      n_rst <= n_rst + 8'h01;
    end
  end

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cfg(input logic s, input logic b, input logic w, input logic [7:0] u,
      input logic [7:0] l, input logic [9:0] k);
    @(negedge clk);
    sme = s;
    bce = b;
    wae = w;
    upper = u;
    lower = l;
    mask = k;
  endtask
  // One-cycle clear; ack select and start request ride along
  task automatic clear(input logic a, input logic s);
    @(negedge clk);
    ack_sel = a;
    start_req = s;
    clr = 1'b1;
    @(negedge clk);
    clr = 1'b0;
    @(negedge clk);
  endtask
  // Event lands a few clocks after the ninth clock falls
  task automatic settle();
    repeat (6) @(negedge clk);
  endtask
  task automatic expect_evt(input logic [7:0] c);
    settle();
    chk1(evt, 1'b1);
    chk8(code, c);
  endtask
  task automatic end_frame();
    m.stop();
    expect_evt(CODE_STOP);
    clear(1'b0, 1'b0);
  endtask

  task automatic s_write7();
    cfg(1'b1, 1'b0, 1'b0, 8'h80, 8'h2A, 10'h000);
    m.start();
    m.send({7'h2A, 1'b0});
    chk1(m_ack, 1'b1);
    expect_evt(CODE_ADDR_WRITE);
    chk1(scl_oe, 1'b1);
    clear(1'b1, 1'b0);
    chk1(evt, 1'b0);
    chk1(scl_oe, 1'b0);
    m.send(8'hA5);
    chk1(m_ack, 1'b1);
    expect_evt(CODE_DATA_ACK);
    chk8(rxd, 8'hA5);
    clear(1'b0, 1'b0);
    m.send(8'h3C);
    chk1(m_ack, 1'b0);
    expect_evt(CODE_DATA_NACK);
    clear(1'b0, 1'b0);
    m.stop();
    expect_evt(CODE_STOP);
    chk1(mreq, 1'b0);
    clear(1'b0, 1'b1);
    chk1(mreq, 1'b1);
    start_req = 1'b0;
  endtask

  task automatic s_match();
    cfg(1'b1, 1'b0, 1'b0, 8'h00, 8'h2A, 10'h000);
    m.start();
    m.send({7'h2A, 1'b0});
    chk1(m_ack, 1'b0);
    settle();
    chk1(evt, 1'b0);
    m.stop();
    cfg(1'b1, 1'b0, 1'b0, 8'h80, 8'h2A, 10'h003);
    m.start();
    m.send({7'h29, 1'b0});
    chk1(m_ack, 1'b1);
    expect_evt(CODE_ADDR_WRITE);
    clear(1'b1, 1'b0);
    end_frame();
    m.start();
    m.send({7'h2E, 1'b0});
    chk1(m_ack, 1'b0);
    m.stop();
    // Masked read address: acked and reported, no data driven
    m.start();
    m.send({7'h2B, 1'b1});
    chk1(m_ack, 1'b1);
    expect_evt(CODE_ADDR_READ);
    clear(1'b0, 1'b0);
    end_frame();
  endtask

  task automatic s_gcall();
    logic [7:0] base;
    cfg(1'b1, 1'b1, 1'b0, 8'h80, 8'h2A, 10'h000);
    m.start();
    m.send(GC_ADDR);
    chk1(m_ack, 1'b1);
    settle();
    chk1(evt, 1'b0);
    m.send(8'h55);
    chk1(m_ack, 1'b1);
    expect_evt(CODE_GC_ACK);
    chk8(rxd, 8'h55);
    clear(1'b0, 1'b0);
    end_frame();
    base = n_rst;
    m.start();
    m.send(GC_ADDR);
    m.send(GC_RESET_BYTE);
    settle();
    chk1(evt, 1'b0);
    chk8(n_rst - base, 8'h01);
    m.stop();
    settle();
    clear(1'b0, 1'b0);
    cfg(1'b1, 1'b0, 1'b0, 8'h80, 8'h2A, 10'h000);
    m.start();
    m.send(GC_ADDR);
    chk1(m_ack, 1'b0);
    m.stop();
  endtask

  task automatic s_wide();
    cfg(1'b1, 1'b0, 1'b1, 8'h82, 8'h5A, 10'h000);
    m.start();
    m.send(8'hF4);
    chk1(m_ack, 1'b1);
    settle();
    chk1(evt, 1'b0);
    m.send(8'h5A);
    chk1(m_ack, 1'b1);
    expect_evt(CODE_ADDR_WRITE);
    clear(1'b1, 1'b0);
    m.send(8'h77);
    expect_evt(CODE_DATA_ACK);
    chk8(rxd, 8'h77);
    clear(1'b1, 1'b0);
    m.start();
    m.send(8'hF5);
    chk1(m_ack, 1'b1);
    expect_evt(CODE_ADDR_READ);
    clear(1'b0, 1'b0);
    end_frame();
    m.start();
    m.send(8'hF4);
    m.send(8'h5A);
    expect_evt(CODE_ADDR_WRITE);
    clear(1'b1, 1'b0);
    m.start();
    m.send(8'hF3);
    chk1(m_ack, 1'b0);
    settle();
    chk1(evt, 1'b0);
    m.stop();
    settle();
    chk1(evt, 1'b0);
    clear(1'b0, 1'b0);
  endtask

  task automatic close_out();
    $display("Counts: %0d compares, %0d mismatches", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Reset, then the scenarios in turn
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    sme = 1'b0;
    bce = 1'b0;
    wae = 1'b0;
    ack_sel = 1'b0;
    clr = 1'b0;
    start_req = 1'b0;
    upper = 8'h00;
    lower = 8'h00;
    mask = 10'h000;
    repeat (12) @(negedge clk);
    chk8(code, CODE_RESET);
    chk1(evt, 1'b0);
    chk1(scl_out, 1'b0);
    chk1(sda_out, 1'b0);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    s_write7();
    s_match();
    s_gcall();
    s_wide();
    close_out();
  end
  // Watchdog well past the expected run of some 2k clocks
  initial begin
    #1_500_000;
    n_mismatch++;
    close_out();
  end
endmodule
`default_nettype wire
